// File: design/sfp_map.vh
// Register offsets, field positions, codes and sizes of the sample buffer.
`ifndef SFP_MAP_VH
`define SFP_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define SFP_ADDR_DATA     8'h1d
`define SFP_ADDR_CFG0     8'h30
`define SFP_ADDR_CFG1     8'h31

// ****************************************
// Fields of buffer_config_0
// ****************************************
`define SFP_CFG_TAG_BIT   6
`define SFP_CFG_MODE_HI   5
`define SFP_CFG_MODE_LO   4
`define SFP_CFG_EXT_BIT   3
`define SFP_CFG_CNT8_BIT  0
`define SFP_CFG0_MASK     8'h79
`define SFP_CFG0_RST      8'h00
`define SFP_CFG1_RST      8'h00

// ****************************************
// Buffer modes
// ****************************************
`define SFP_MODE_OFF      2'h0
`define SFP_MODE_NORMAL   2'h1
`define SFP_MODE_STREAM   2'h2
`define SFP_MODE_TRIG     2'h3

// ****************************************
// Channel tags
// ****************************************
`define SFP_TAG_X         2'h0
`define SFP_TAG_Y         2'h1
`define SFP_TAG_Z         2'h2
`define SFP_TAG_T         2'h3

// ****************************************
// Storage sizes
// ****************************************
`define SFP_DEPTH_FULL    10'h140
`define SFP_DEPTH_THREE   10'h13e
`define SFP_THREE_CH      3'h3

`endif

// File: design/sfp_mem.v
// Sample storage memory with one write port and a registered read port.
`timescale 1ns/1ps
`default_nettype none

module sfp_mem
#(
   parameter WIDTH  = 16,
   parameter DEPTH  = 320,
   parameter ADDR_W = 9
)
(
   input  wire              clock,
   input  wire              wr_en,
   input  wire [ADDR_W-1:0] wr_addr,
   input  wire [WIDTH-1:0]  wr_data,
   input  wire [ADDR_W-1:0] rd_addr,
   output reg  [WIDTH-1:0]  rd_data
);

   // Storage array; contents are undefined until written.
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];

   // ****************************************
   // Write and registered read
   // ****************************************
   // Read data always follow the read address by one cycle.
   always @(posedge clock)
   begin
      if (wr_en)
      begin
         mem_reg[wr_addr] <= wr_data;
      end
      rd_data <= mem_reg[rd_addr];
   end

endmodule

`default_nettype wire

// File: design/sfp_sample_fifo_packer.v
// Sample buffer: packs enabled channels into storage and drains them through one data address.
//
// Summary of operation
// [R1] Storage holds 320 sample words.
// [R2] Three enabled channels limit depth to 318.
// [R3] Enabled channels written X,Y,Z,T from zero.
// [R4] Config bit 6 switches channel tagging.
// [R5] Each tagged sample preceded by 2-bit code.
// [R6] Tags: X 00, Y 01, Z 10, T 11.
// [R7] Tags generated at readout, never stored.
// [R8] Burst read gives tag then sample per channel.
// [R9] Address stops incrementing at data address.
// [R10] Lower start address increments up, then holds.
// [R11] Host reads whole sample set per burst.
// [R12] Trigger freezes earlier data in buffer.
// [R13] Mode 00 stores nothing, reads zero.
// [R14] Mode 01 fills then stops until read.
// [R15] Mode 10 drops oldest set when full.
// [R16] Mode 11 stores programmed count, then freezes.
// [R17] Reset or disable empties and restarts buffer.
// [R18] Readout tracks next channel across bursts.
`include "sfp_map.vh"
`timescale 1ns/1ps
`default_nettype none

module sfp_sample_fifo_packer
#(
   parameter DEPTH  = 320,
   parameter ADDR_W = 9
)
(
   input  wire              clock,
   input  wire              rst,
   input  wire [3:0]        chan_en,
   input  wire              set_valid,
   input  wire [15:0]       set_x,
   input  wire [15:0]       set_y,
   input  wire [15:0]       set_z,
   input  wire [15:0]       set_t,
   output wire              set_ready,
   input  wire              activity_event,
   input  wire              fsync_pin,
   input  wire              txn_start,
   input  wire [7:0]        txn_addr,
   input  wire              byte_rd,
   input  wire              byte_wr,
   input  wire [7:0]        byte_wdata,
   output reg  [7:0]        byte_rdata,
   output reg  [7:0]        cur_addr_reg,
   output reg  [ADDR_W:0]   count_reg,
   output wire              buf_full,
   output wire              buf_ready,
   output reg               frozen_reg
);

   // Readout byte phases.
   localparam PH_TAG = 2'h0;
   localparam PH_HI  = 2'h1;
   localparam PH_LO  = 2'h2;

   reg [7:0]        cfg0_reg;      // Mode, tag enable, external trigger, count bit 8.
   reg [7:0]        cfg1_reg;      // Count bits 7:0.
   reg [ADDR_W-1:0] wr_ptr_reg;    // Next location to write.
   reg [ADDR_W-1:0] rd_ptr_reg;    // Oldest unread location.
   reg [1:0]        wr_chan_reg;   // Channel being written.
   reg [1:0]        rd_chan_reg;   // Channel of the oldest word.
   reg [1:0]        phase_reg;     // Readout byte phase.
   reg              busy_reg;      // A set is being written.
   reg [63:0]       set_reg;       // Latched sample set, T Z Y X.
   reg              triggered_reg; // Trigger seen, counting.
   reg [8:0]        post_reg;      // Samples still to store after trigger.
   reg              fs_meta_reg;   // Pin synchroniser, first stage.
   reg              fs_sync_reg;   // Pin synchroniser, second stage.
   reg              fs_prev_reg;   // Delayed copy for edge detection.
   wire [15:0]      mem_q;         // Word at the read pointer.

   // ****************************************
   // Helpers
   // ****************************************
   // Finds the next enabled channel after cur, cyclically.
   function [1:0] next_ch;
      input [1:0] cur;
      input [3:0] en;
      reg   [1:0] c;
      reg         found;
      integer     i;
      begin
         found   = 1'b0;
         next_ch = cur;
         c       = cur;
         for (i = 0; i < 4; i = i + 1)
         begin
            c = c + 2'h1;
            if (en[c] && !found)
            begin
               next_ch = c;
               found   = 1'b1;
            end
         end
      end
   endfunction

   wire [1:0] mode   = cfg0_reg[`SFP_CFG_MODE_HI:`SFP_CFG_MODE_LO];
   wire       tag_en = cfg0_reg[`SFP_CFG_TAG_BIT];                     // R4
   // Tag enable as it will stand after this edge, so that a buffer enabled
   // together with tagging starts its first word on a tag byte.
   wire       tag_nx = (byte_wr && (cur_addr_reg == `SFP_ADDR_CFG0))
                     ? byte_wdata[`SFP_CFG_TAG_BIT] : tag_en;
   wire       ext_en = cfg0_reg[`SFP_CFG_EXT_BIT];
   wire [8:0] post_count = {cfg0_reg[`SFP_CFG_CNT8_BIT], cfg1_reg};
   wire       flush  = (mode == `SFP_MODE_OFF);                         // R17

   // Number of enabled channels, i.e. words per set.
   wire [2:0] nen = {2'h0, chan_en[0]} + {2'h0, chan_en[1]}
                  + {2'h0, chan_en[2]} + {2'h0, chan_en[3]};

   // Usable depth shrinks so that only whole sets of three fit.
   wire [ADDR_W:0] depth = (nen == `SFP_THREE_CH) ? `SFP_DEPTH_THREE   // R2
                                                  : `SFP_DEPTH_FULL;  // R1
   wire [ADDR_W:0] free  = depth - count_reg;
   wire [ADDR_W:0] nen_w = {{(ADDR_W-2){1'b0}}, nen};

   assign buf_full  = (count_reg == depth);
   assign buf_ready = (count_reg != {(ADDR_W+1){1'b0}});
   assign set_ready = !busy_reg;

   // ****************************************
   // Trigger pin synchroniser
   // ****************************************
   // The pin passes two flip-flops; only the second feeds the edge detector.
   always @(posedge clock)
   begin
      if (rst)
      begin
         fs_meta_reg <= 1'b0;
         fs_sync_reg <= 1'b0;
         fs_prev_reg <= 1'b0;
      end
      else
      begin
         fs_meta_reg <= fsync_pin;
         fs_sync_reg <= fs_meta_reg;
         fs_prev_reg <= fs_sync_reg;
      end
   end

   wire trig_ev = activity_event || (ext_en && fs_sync_reg && !fs_prev_reg);
   // A trigger is taken once per arming; a zero count stops a set already in flight at once.
   wire trig_take = (mode == `SFP_MODE_TRIG) && !triggered_reg && !frozen_reg && trig_ev;

   // ****************************************
   // Write and read decisions
   // ****************************************
   // Data address reads and pops.
   wire at_data  = (cur_addr_reg == `SFP_ADDR_DATA);
   wire rd_live  = byte_rd && at_data && !flush && buf_ready;
   wire pop      = rd_live && (phase_reg == PH_LO);

   // A set is taken unless busy, off, with no channel enabled, frozen, or in normal mode with no room.
   wire accept   = set_valid && !busy_reg && !flush && (nen != 3'h0) && !frozen_reg
                 && ((mode != `SFP_MODE_NORMAL) || (free >= nen_w));      // R14
   // Stream and trigger modes drop the oldest whole set to make room.
   wire discard  = accept && (mode != `SFP_MODE_NORMAL) && (free < nen_w); // R15
   wire last_wr  = busy_reg && (next_ch(wr_chan_reg, chan_en) <= wr_chan_reg);
   wire post_end = triggered_reg && busy_reg && (post_reg == 9'h001);

   // Read pointer advance, wrapped at the usable depth.
   wire [ADDR_W:0] rd_adv = (discard ? nen_w : {(ADDR_W+1){1'b0}})
                          + {{ADDR_W{1'b0}}, pop};
   wire [ADDR_W:0] rd_sum = {1'b0, rd_ptr_reg} + rd_adv;
   wire [ADDR_W:0] rd_wrp = (rd_sum >= depth) ? rd_sum - depth : rd_sum;
   wire [ADDR_W:0] wr_sum = {1'b0, wr_ptr_reg} + {{ADDR_W{1'b0}}, 1'b1};

   // Word of the latched set for the channel being written.
   wire [15:0] wr_word = set_reg[{wr_chan_reg, 4'h0} +: 16];              // R3

   // ****************************************
   // Storage
   // ****************************************
   sfp_mem
   #(
      .WIDTH  (16),
      .DEPTH  (DEPTH),
      .ADDR_W (ADDR_W)
   )
   u_mem
   (
      .clock   (clock),
      .wr_en   (busy_reg),
      .wr_addr (wr_ptr_reg),
      .wr_data (wr_word),
      .rd_addr (rd_ptr_reg),
      .rd_data (mem_q)
   );

   // ****************************************
   // Register address pointer
   // ****************************************
   // The pointer steps after each byte, except at the data address where it holds.
   always @(posedge clock)
   begin
      if (rst)
      begin
         cur_addr_reg <= 8'h00;
      end
      else if (txn_start)
      begin
         cur_addr_reg <= txn_addr;
      end
      else if ((byte_rd || byte_wr) && !at_data)
      begin
         cur_addr_reg <= cur_addr_reg + 8'h01;                           // R10
      end
      else
      begin
         cur_addr_reg <= cur_addr_reg;                                   // R9
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   // Reserved bits of the first configuration register are kept at zero.
   always @(posedge clock)
   begin
      if (rst)
      begin
         cfg0_reg <= `SFP_CFG0_RST;
         cfg1_reg <= `SFP_CFG1_RST;
      end
      else if (byte_wr && (cur_addr_reg == `SFP_ADDR_CFG0))
      begin
         cfg0_reg <= byte_wdata & `SFP_CFG0_MASK;
      end
      else if (byte_wr && (cur_addr_reg == `SFP_ADDR_CFG1))
      begin
         cfg1_reg <= byte_wdata;
      end
   end

   // ****************************************
   // Read data
   // ****************************************
   // The tag byte comes from the channel tracker, so it takes no storage.
   always @(posedge clock)
   begin
      if (rst)
      begin
         byte_rdata <= 8'h00;
      end
      else if (byte_rd)
      begin
         case (cur_addr_reg)
            `SFP_ADDR_DATA:
            begin
               if (!rd_live)
               begin
                  byte_rdata <= 8'h00;                                   // R13
               end
               else if (phase_reg == PH_TAG)
               begin
                  byte_rdata <= {6'h00, rd_chan_reg};                    // R5 R6 R7
               end
               else if (phase_reg == PH_HI)
               begin
                  byte_rdata <= mem_q[15:8];                             // R8
               end
               else
               begin
                  byte_rdata <= mem_q[7:0];                              // R8
               end
            end
            `SFP_ADDR_CFG0: byte_rdata <= cfg0_reg;
            `SFP_ADDR_CFG1: byte_rdata <= cfg1_reg;
            default:        byte_rdata <= 8'h00;
         endcase
      end
   end

   // ****************************************
   // Readout sequencing
   // ****************************************
   // Phase and channel survive between bursts so bytes stay aligned.
   always @(posedge clock)
   begin
      if (rst || flush)
      begin
         phase_reg   <= tag_nx ? PH_TAG : PH_HI;                         // R17
         rd_chan_reg <= next_ch(`SFP_TAG_T, chan_en);
      end
      else if (discard)
      begin
         phase_reg   <= tag_en ? PH_TAG : PH_HI;
         rd_chan_reg <= rd_chan_reg;
      end
      else if (rd_live)
      begin
         case (phase_reg)
            PH_TAG:  phase_reg <= PH_HI;
            PH_HI:   phase_reg <= PH_LO;
            default:
            begin
               phase_reg   <= tag_en ? PH_TAG : PH_HI;                   // R4
               rd_chan_reg <= next_ch(rd_chan_reg, chan_en);             // R18
            end
         endcase
      end
   end

   // ****************************************
   // Pointers, count and set writer
   // ****************************************
   // One enabled channel is written per cycle while a set is in flight.
   always @(posedge clock)
   begin
      if (rst || flush)
      begin
         wr_ptr_reg  <= {ADDR_W{1'b0}};                                  // R17
         rd_ptr_reg  <= {ADDR_W{1'b0}};
         count_reg   <= {(ADDR_W+1){1'b0}};
         wr_chan_reg <= `SFP_TAG_X;
         busy_reg    <= 1'b0;
         set_reg     <= 64'h0;
      end
      else
      begin
         rd_ptr_reg <= rd_wrp[ADDR_W-1:0];
         count_reg  <= count_reg + {{ADDR_W{1'b0}}, busy_reg}
                     - {{ADDR_W{1'b0}}, pop}
                     - (discard ? nen_w : {(ADDR_W+1){1'b0}});
         if (busy_reg)
         begin
            wr_ptr_reg  <= (wr_sum >= depth) ? {ADDR_W{1'b0}}             // R3
                                             : wr_sum[ADDR_W-1:0];
            wr_chan_reg <= next_ch(wr_chan_reg, chan_en);
            busy_reg    <= !last_wr && !post_end && !(trig_take && (post_count == 9'h000));
         end
         else if (accept)
         begin
            set_reg     <= {set_t, set_z, set_y, set_x};
            wr_chan_reg <= next_ch(`SFP_TAG_T, chan_en);
            busy_reg    <= 1'b1;
         end
      end
   end

   // ****************************************
   // Trigger capture
   // ****************************************
   // After a trigger the programmed number of samples is stored, then the
   // buffer freezes so the history before the event stays for the host.
   // Writing the first configuration register re-arms the capture.
   always @(posedge clock)
   begin
      if (rst || flush || (byte_wr && (cur_addr_reg == `SFP_ADDR_CFG0)))
      begin
         triggered_reg <= 1'b0;
         post_reg      <= 9'h000;
         frozen_reg    <= 1'b0;
      end
      else if (trig_take)
      begin
         triggered_reg <= (post_count != 9'h000);                        // R16
         post_reg      <= post_count;
         frozen_reg    <= (post_count == 9'h000);                        // R12
      end
      else if (post_end)
      begin
         triggered_reg <= 1'b0;
         frozen_reg    <= 1'b1;                                          // R12
      end
      else if (triggered_reg && busy_reg)
      begin
         post_reg <= post_reg - 9'h001;                                  // R16
      end
   end

endmodule

`default_nettype wire

// File: testbench/sfp_host_model.sv
// Host model that reaches the buffer registers over the byte port.
`timescale 1ns/1ps
`default_nettype none
module sfp_host_model
(
   input  wire logic       clock,
   input  wire logic [7:0] byte_rdata,
   output var  logic       txn_start,
   output var  logic [7:0] txn_addr,
   output var  logic       byte_rd,
   output var  logic       byte_wr,
   output var  logic [7:0] byte_wdata
);
   // Idle bus from time zero.
   initial
   begin
      txn_start = 1'b0;
      txn_addr = 8'h00;
      byte_rd = 1'b0;
      byte_wr = 1'b0;
      byte_wdata = 8'h00;
   end
   // Opens a transaction at a start address.
   task automatic start(input logic [7:0] a);
      @(posedge clock);
      txn_start <= 1'b1;
      txn_addr <= a;
      @(posedge clock);
      txn_start <= 1'b0;
   endtask
   // Reads one byte; data land on the edge that takes the strobe and are sampled one edge later.
   task automatic rd(output logic [7:0] d);
      @(posedge clock);
      byte_rd <= 1'b1;
      @(posedge clock);
      byte_rd <= 1'b0;
      @(posedge clock);
      d = byte_rdata;
   endtask
   // Writes one byte at the current pointer.
   task automatic wr(input logic [7:0] d);
      @(posedge clock);
      byte_wr <= 1'b1;
      byte_wdata <= d;
      @(posedge clock);
      byte_wr <= 1'b0;
   endtask
endmodule
`default_nettype wire

// File: testbench/sfp_monitor.sv
// Concurrent checks on the ports of the sample buffer.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_map.vh"
module sfp_monitor
#(
   parameter DEPTH  = 320,
   parameter ADDR_W = 9
)
(
   input wire logic              clock,
   input wire logic              rst,
   input wire logic [3:0]        chan_en,
   input wire logic              txn_start,
   input wire logic [7:0]        txn_addr,
   input wire logic              byte_rd,
   input wire logic              byte_wr,
   input wire logic [7:0]        byte_rdata,
   input wire logic [7:0]        cur_addr_reg,
   input wire logic [ADDR_W:0]   count_reg,
   input wire logic              buf_full,
   input wire logic              set_ready,
   input wire logic              frozen_reg
);
   // Usable depth follows the number of enabled channels.
   logic [9:0] lim;
   assign lim = ($countones(chan_en) == 3) ? `SFP_DEPTH_THREE : `SFP_DEPTH_FULL;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // A register access that is not a transaction start.
   sequence acc_s;
      (byte_rd || byte_wr) && !txn_start;
   endsequence
   // The pointer rests on the data address.
   sequence at_data_s;
      cur_addr_reg == `SFP_ADDR_DATA;
   endsequence
   count_max_a: assert property (count_reg <= `SFP_DEPTH_FULL)
      else $error("stored count above storage size");
   full_depth_a: assert property (buf_full == (count_reg == lim))
      else $error("full flag disagrees with usable depth");
   addr_hold_a: assert property (acc_s ##0 at_data_s |=> at_data_s)
      else $error("pointer left the data address");
   addr_step_a: assert property (acc_s ##0 (cur_addr_reg != `SFP_ADDR_DATA)
      |=> cur_addr_reg == $past(cur_addr_reg) + 8'h01)
      else $error("pointer did not step by one");
   txn_load_a: assert property (txn_start |=> cur_addr_reg == $past(txn_addr))
      else $error("start address not loaded");
   frozen_hold_a: assert property (frozen_reg && !byte_rd && !byte_wr
      |=> count_reg == $past(count_reg))
      else $error("frozen buffer changed its count");
   rdata_hold_a: assert property (!byte_rd |=> $stable(byte_rdata))
      else $error("read data moved without a read");
   reset_empty_a: assert property (disable iff (1'b0) rst |=> count_reg == 10'h000
      && cur_addr_reg == 8'h00 && !frozen_reg && set_ready)
      else $error("reset did not empty the buffer");
endmodule
bind sfp_sample_fifo_packer sfp_monitor #(.DEPTH(DEPTH), .ADDR_W(ADDR_W)) u_mon
(
   .clock(clock), .rst(rst), .chan_en(chan_en), .txn_start(txn_start),
   .txn_addr(txn_addr), .byte_rd(byte_rd), .byte_wr(byte_wr), .byte_rdata(byte_rdata),
   .cur_addr_reg(cur_addr_reg), .count_reg(count_reg), .buf_full(buf_full),
   .set_ready(set_ready), .frozen_reg(frozen_reg)
);
`default_nettype wire

// File: testbench/sfp_sample_fifo_packer_tb.sv
// Self-checking bench of the sample buffer with a host on its register port.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_map.vh"
module sfp_sample_fifo_packer_tb;
   logic        clock;
   logic        rst;
   logic [3:0]  chan_en;
   logic        set_valid;
   logic [15:0] set_x;
   logic [15:0] set_y;
   logic [15:0] set_z;
   logic [15:0] set_t;
   logic        activity_event;
   logic        fsync_pin;
   logic        set_ready;
   logic        txn_start;
   logic [7:0]  txn_addr;
   logic        byte_rd;
   logic        byte_wr;
   logic [7:0]  byte_wdata;
   logic [7:0]  byte_rdata;
   logic [7:0]  cur_addr_reg;
   logic [9:0]  count_reg;
   logic        buf_full;
   logic        buf_ready;
   logic        frozen_reg;
   logic [31:0] seed;
   logic [17:0] exp_q[$];
   logic [1:0]  mode;
   logic        tag_on;
   logic [7:0]  d;
   int          trig_left;
   int          miscompares;
   int          n_tests;
   sfp_sample_fifo_packer u_dut (.clock(clock), .rst(rst), .chan_en(chan_en),
      .set_valid(set_valid), .set_x(set_x), .set_y(set_y), .set_z(set_z), .set_t(set_t),
      .set_ready(set_ready), .activity_event(activity_event), .fsync_pin(fsync_pin),
      .txn_start(txn_start), .txn_addr(txn_addr), .byte_rd(byte_rd), .byte_wr(byte_wr),
      .byte_wdata(byte_wdata), .byte_rdata(byte_rdata), .cur_addr_reg(cur_addr_reg),
      .count_reg(count_reg), .buf_full(buf_full), .buf_ready(buf_ready),
      .frozen_reg(frozen_reg));
   sfp_host_model u_host (.clock(clock), .byte_rdata(byte_rdata), .txn_start(txn_start),
      .txn_addr(txn_addr), .byte_rd(byte_rd), .byte_wr(byte_wr), .byte_wdata(byte_wdata));
   // Xorshift source of sample words.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction
   // Compares a seen value with the expected one.
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      n_tests++;
      if (seen !== want)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // Offers one random set and updates the expected contents.
   task automatic push();
      logic [15:0] w[4];
      int k;
      int n;
      for (k = 0; k < 4; k++)
      begin
         seed = xs(seed);
         w[k] = seed[15:0];
      end
      n = $countones(chan_en);
      @(posedge clock);
      set_valid <= 1'b1;
      {set_x, set_y, set_z, set_t} <= {w[0], w[1], w[2], w[3]};
      @(posedge clock);
      set_valid <= 1'b0;
      @(posedge clock);
      for (k = 0; k < 10 && set_ready !== 1'b1; k++)
         @(posedge clock);
      if (mode == `SFP_MODE_OFF || trig_left == 0)
         return;
      if (exp_q.size() + n > (n == 3 ? 318 : 320))
      begin
         if (mode == `SFP_MODE_NORMAL)
            return;
         repeat (n) void'(exp_q.pop_front());
      end
      for (k = 0; k < 4; k++)
         if (chan_en[k])
            exp_q.push_back({k[1:0], w[k]});
      if (trig_left > 0)
         trig_left -= n;
   endtask
   // Reads n words in one burst from start address a.
   task automatic drain(input int n, input logic [7:0] a);
      logic [17:0] e;
      u_host.start(a);
      if (a != `SFP_ADDR_DATA)
      begin
         u_host.rd(d);
         chk({8'h00, d}, 16'h0000);
      end
      repeat (n)
      begin
         e = exp_q.pop_front();
         if (tag_on)
         begin
            u_host.rd(d);
            chk({8'h00, d}, {14'h0000, e[17:16]});
         end
         u_host.rd(d);
         chk({8'h00, d}, {8'h00, e[15:8]});
         u_host.rd(d);
         chk({8'h00, d}, {8'h00, e[7:0]});
      end
      chk({8'h00, cur_addr_reg}, {8'h00, `SFP_ADDR_DATA});
   endtask
   // Writes both configuration bytes in one burst.
   task automatic cfg(input logic [1:0] m, input logic t, input logic [7:0] c1);
      mode = m;
      tag_on = t;
      trig_left = -1;
      if (m == `SFP_MODE_OFF)
         exp_q.delete();
      u_host.start(`SFP_ADDR_CFG0);
      u_host.wr({1'b0, t, m, 4'h0});
      u_host.wr(c1);
   endtask
   // Ends the run with the verdict.
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   // Cuts a hang short.
   initial
   begin
      #1000000;
      miscompares++;
      stop_test();
   end
   // Main sequence.
   initial
   begin : main
      logic [3:0] tab[6];
      tab = '{4'h1, 4'h3, 4'h9, 4'h7, 4'hb, 4'hf};
      {rst, chan_en, set_valid, activity_event, fsync_pin} = {1'b1, 4'hf, 3'h0};
      {set_x, set_y, set_z, set_t} = 64'h0;
      seed = 32'h0000004c;
      mode = `SFP_MODE_OFF;
      tag_on = 1'b0;
      trig_left = -1;
      miscompares = 0;
      n_tests = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      chk({6'h00, count_reg}, 16'h0000);
      chk({15'h0000, buf_ready}, 16'h0000);
      u_host.start(`SFP_ADDR_CFG0);
      u_host.rd(d);
      chk({8'h00, d}, 16'h0000);
      repeat (2) push();
      chk({6'h00, count_reg}, 16'h0000);
      u_host.start(`SFP_ADDR_DATA);
      u_host.rd(d);
      chk({8'h00, d}, 16'h0000);
      foreach (tab[i])
      begin
         chan_en <= tab[i];
         cfg(`SFP_MODE_NORMAL, i[0], 8'h00);
         repeat (2) push();
         chk({6'h00, count_reg}, 16'($countones(tab[i]) * 2));
         drain($countones(tab[i]), 8'h1c);
         drain($countones(tab[i]), `SFP_ADDR_DATA);
         cfg(`SFP_MODE_OFF, 1'b0, 8'h00);
      end
      chan_en <= 4'h7;
      cfg(`SFP_MODE_NORMAL, 1'b0, 8'h00);
      repeat (107) push();
      chk({15'h0000, buf_full}, 16'h0001);
      chk({6'h00, count_reg}, 16'h013e);
      drain(3, `SFP_ADDR_DATA);
      push();
      drain(318, `SFP_ADDR_DATA);
      cfg(`SFP_MODE_OFF, 1'b0, 8'h00);
      chan_en <= 4'hf;
      cfg(`SFP_MODE_STREAM, 1'b1, 8'h00);
      repeat (81) push();
      chk({6'h00, count_reg}, 16'h0140);
      chk({15'h0000, buf_ready}, 16'h0001);
      drain(320, `SFP_ADDR_DATA);
      cfg(`SFP_MODE_OFF, 1'b0, 8'h00);
      chk({6'h00, count_reg}, 16'h0000);
      chan_en <= 4'h1;
      cfg(`SFP_MODE_TRIG, 1'b0, 8'h05);
      repeat (3) push();
      @(posedge clock);
      activity_event <= 1'b1;
      @(posedge clock);
      activity_event <= 1'b0;
      trig_left = 5;
      repeat (8) push();
      chk({15'h0000, frozen_reg}, 16'h0001);
      chk({6'h00, count_reg}, 16'h0008);
      drain(8, `SFP_ADDR_DATA);
      // Re-arm with the external trigger pin as source and a count of two.
      u_host.start(`SFP_ADDR_CFG0);
      u_host.wr(8'h38);
      u_host.wr(8'h02);
      trig_left = -1;
      repeat (2) push();
      @(posedge clock);
      fsync_pin <= 1'b1;
      repeat (4) @(posedge clock);
      fsync_pin <= 1'b0;
      trig_left = 2;
      repeat (4) push();
      chk({15'h0000, frozen_reg}, 16'h0001);
      chk({6'h00, count_reg}, 16'h0004);
      drain(4, `SFP_ADDR_DATA);
      stop_test();
   end
endmodule
`default_nettype wire
